// [fwp_defs.svh]
`ifndef FWP_DEFS_SVH
`define FWP_DEFS_SVH
// instruction codes
`define FWP_OP_WREN 8'h06
`define FWP_OP_WRDI 8'h04
`define FWP_OP_PP 8'h02
`define FWP_OP_QPP 8'h32
`define FWP_OP_SE 8'h20
`define FWP_OP_BE32 8'h52
`define FWP_OP_BE64 8'hD8
`define FWP_OP_CE1 8'hC7
`define FWP_OP_CE2 8'h60
`define FWP_OP_WRSR1 8'h01
`define FWP_OP_WRSR2 8'h31
`define FWP_OP_WRSR3 8'h11
`define FWP_OP_RDSR1 8'h05
`define FWP_OP_RDSR2 8'h35
`define FWP_OP_RDSR3 8'h15
`define FWP_OP_SUSP 8'h75
`define FWP_OP_PD 8'hB9
`define FWP_OP_REL 8'hAB
`define FWP_OP_UNLOCK 8'h39
`define FWP_OP_ERSEC 8'h44
`define FWP_OP_PRSEC 8'h42
// lock bit map
`define FWP_LOCK_N 542
`define FWP_LOCK_W 10
`define FWP_ADDR_W 25
`define FWP_BOT_BLK 9'h000
`define FWP_TOP_BLK 9'h1FF
`define FWP_BOT_SECT 6'h00
`define FWP_TOP_SECT 6'h01
`define FWP_BLK_BASE 10'h01F
// protect range decode
`define FWP_BP_NONE 4'h0
`define FWP_BP_ALL 4'hA
`define FWP_NBLK 10'h200
// status bit positions
`define FWP_S1_BP 5:2
`define FWP_S1_TB 6
`define FWP_S1_SRP 7
`define FWP_S2_SRL 0
`define FWP_S2_CMP 6
`define FWP_S3_WPS 2
// timing
`define FWP_CLK_PERIOD_NS 10
`define FWP_PUW_TIME_US 5000
`define FWP_PUW_CNT_W 23
`endif

// [fwp_pkg.sv]
`include "fwp_defs.svh"
package fwp_pkg;
  typedef enum logic [1:0] {FWP_IDLE, FWP_CHECK, FWP_BUSY} fwp_state_type;

  // one decoded instruction from the serial front end
  typedef struct packed {
    logic [7:0] op;
    logic [`FWP_ADDR_W-1:0] addr;
    logic [7:0] data;
  } fwp_instr_type;

  // whole state of the protection block
  typedef struct packed {
    fwp_state_type st;
    logic [`FWP_PUW_CNT_W-1:0] puw_cnt;
    logic puw_done;
    logic pd;
    logic busy;
    logic write_enable_latch;
    logic [3:0] bp;
    logic tb;
    logic status_protect_bit;
    logic status_lock_bit;
    logic cmp;
    logic protect_scheme_select;
    fwp_instr_type cur;
    logic ready;
    logic done;
    logic ign;
    logic start;
    logic [7:0] sr1;
    logic [7:0] sr2;
  } fwp_regs_type;

  // whole state of the lock bit store
  typedef struct packed {
    logic [`FWP_LOCK_N-1:0] lock;
    logic rd;
    logic any;
  } fwp_lock_type;
endpackage : fwp_pkg

// [fwp_lock_mem.sv]
`timescale 1ns/1ps
`include "fwp_defs.svh"
module fwp_lock_mem (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic set_all_in,
  input wire logic clr_en_in,
  input wire logic [`FWP_LOCK_W-1:0] clr_idx_in,
  input wire logic [`FWP_LOCK_W-1:0] rd_idx_in,
  // read data
  output logic rd_out,
  output logic any_out
);
  fwp_pkg::fwp_lock_type q, d;

  // set all, clear one, registered read
  always_comb begin
    d = q;
    if (set_all_in) begin
      d.lock = '1;
    end else if (clr_en_in) begin
      d.lock[clr_idx_in] = 1'b0;
    end
    d.rd = q.lock[rd_idx_in];
    d.any = |q.lock;
  end

  // every region starts locked
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign rd_out = q.rd;
  assign any_out = q.any;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_lock_set_all: assert property (set_all_in |=> (&q.lock))
    else $error("lock bits not all set");
  a_lock_unlock: assert property (
    (clr_en_in && !set_all_in) |=> !q.lock[$past(clr_idx_in)])
    else $error("unlock did not clear lock bit");
endmodule : fwp_lock_mem

// [fwp_protect.sv]
`timescale 1ns/1ps
`include "fwp_defs.svh"
// Behaviour
// - supply below threshold: everything held at defaults, no instruction taken.
// - after supply good, write-type instructions refused for the power-up delay.
// - power-up leaves the write enable latch clear.
// - program, erase and status write need the latch set first.
// - latch clears automatically when program, erase or status write ends.
// - in power-down only release-from-power-down is obeyed.
// - 510 block lock bits plus 32 sector lock bits in end blocks.
// - locked region ignores program and erase silently; unlocked proceeds.
// - every lock bit is set at power-on.
// - unlock instruction 39h clears the lock bit of the addressed region.
// - scheme select 0 uses range bits, 1 uses lock bits only.
// - status write needs status lock permitting and latch set.
// - busy bit S0 high during program, erase, status and security writes.
// - while busy only read status and suspend are obeyed.
// - busy clears when the internal operation completes.
// - latch readable at S1, set by write enable.
// - latch cleared by write disable, by unlock and when an accepted write-type instruction ends; a refused one leaves it set.
// - four range bits S5..S2, written by status write, default 0.
// - top/bottom bit picks range start: top at 0, bottom at 1.
// - complement bit S14 inverts the protected region.
// - status-protect set, lock clear and protect pin low refuse status writes.
module fwp_protect #(
  parameter int PUW_CYCLES =
    `FWP_PUW_TIME_US * 1000 / `FWP_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  // supply monitor and protect pin
  input wire logic VCC_OK_IN,
  input wire logic WP_N_IN,
  // decoded instructions
  input wire logic INSTR_VALID_IN,
  input wire fwp_pkg::fwp_instr_type INSTR_IN,
  output logic INSTR_READY_OUT,
  output logic INSTR_DONE_OUT,
  output logic INSTR_IGNORED_OUT,
  // array engine
  output logic ARRAY_START_OUT,
  output fwp_pkg::fwp_instr_type ARRAY_CMD_OUT,
  input wire logic OP_DONE_IN,
  // status
  output logic [7:0] STATUS1_OUT,
  output logic [7:0] STATUS2_OUT,
  output logic PROT_SCHEME_OUT,
  output logic POWER_DOWN_OUT,
  output logic WRITE_READY_OUT
);
  localparam logic [`FWP_PUW_CNT_W-1:0] PUW_LAST =
    `FWP_PUW_CNT_W'(PUW_CYCLES - 1);

  fwp_pkg::fwp_regs_type q, d;
  logic lk_rd;
  logic lk_any;
  logic lk_clr;
  logic [`FWP_LOCK_W-1:0] lk_rd_idx;
  logic [`FWP_LOCK_W-1:0] lk_clr_idx;
  logic is_prog, is_erase, is_ce, is_wrsr, is_sec, is_wr;
  logic sr_ok, prot, take;

  // lock bit index of a target address
  function automatic logic [`FWP_LOCK_W-1:0] lock_idx(
    input logic [`FWP_ADDR_W-1:0] a);
    logic [8:0] b;
    b = a[`FWP_ADDR_W-1:16];
    if (b == `FWP_BOT_BLK) begin
      lock_idx = {`FWP_BOT_SECT, a[15:12]};
    end else if (b == `FWP_TOP_BLK) begin
      lock_idx = {`FWP_TOP_SECT, a[15:12]};
    end else begin
      lock_idx = {1'b0, b} + `FWP_BLK_BASE;
    end
  endfunction : lock_idx

  // range bit hit for one block address
  function automatic logic bp_hit(
    input logic [`FWP_ADDR_W-1:0] a, input logic [3:0] bp,
    input logic tb, input logic cmp);
    logic [9:0] n;
    logic [9:0] b;
    logic inr;
    b = {1'b0, a[`FWP_ADDR_W-1:16]};
    if (bp == `FWP_BP_NONE) begin
      n = 10'h000;
    end else if (bp >= `FWP_BP_ALL) begin
      n = `FWP_NBLK;
    end else begin
      n = 10'h001 << (bp - 4'h1);
    end
    inr = tb ? (b < n) : (b >= (`FWP_NBLK - n));
    bp_hit = inr ^ cmp;
  endfunction : bp_hit

  // instruction classes of the latched instruction
  always_comb begin
    is_prog = (q.cur.op == `FWP_OP_PP) || (q.cur.op == `FWP_OP_QPP);
    is_ce = (q.cur.op == `FWP_OP_CE1) || (q.cur.op == `FWP_OP_CE2);
    is_erase = is_ce || (q.cur.op == `FWP_OP_SE) ||
               (q.cur.op == `FWP_OP_BE32) || (q.cur.op == `FWP_OP_BE64);
    is_wrsr = (q.cur.op == `FWP_OP_WRSR1) ||
              (q.cur.op == `FWP_OP_WRSR2) || (q.cur.op == `FWP_OP_WRSR3);
    is_sec = (q.cur.op == `FWP_OP_ERSEC) || (q.cur.op == `FWP_OP_PRSEC);
    is_wr = is_prog || is_erase || is_wrsr || is_sec;
  end

  // status write permission and array protection
  always_comb begin
    sr_ok = !q.status_lock_bit && (!q.status_protect_bit || WP_N_IN);
    if (q.protect_scheme_select) begin
      prot = is_ce ? lk_any : lk_rd;
    end else if (is_ce) begin
      prot = q.cmp ? (q.bp < `FWP_BP_ALL) : (q.bp != `FWP_BP_NONE);
    end else begin
      prot = bp_hit(q.cur.addr, q.bp, q.tb, q.cmp);
    end
  end

  // lock store requests
  always_comb begin
    take = INSTR_VALID_IN && q.ready;
    lk_rd_idx = lock_idx(INSTR_IN.addr);
    lk_clr_idx = lock_idx(q.cur.addr);
    lk_clr = (q.st == fwp_pkg::FWP_CHECK) && !q.pd &&
             (q.cur.op == `FWP_OP_UNLOCK) && q.write_enable_latch && q.puw_done;
  end

  // next state
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.ign = 1'b0;
    d.start = 1'b0;
    if (!q.puw_done) begin
      d.puw_cnt = q.puw_cnt + `FWP_PUW_CNT_W'(1);
      d.puw_done = (q.puw_cnt == PUW_LAST);
    end
    case (q.st)
      fwp_pkg::FWP_IDLE: begin
        if (take && q.pd) begin
          if (INSTR_IN.op == `FWP_OP_REL) begin
            d.pd = 1'b0;
            d.done = 1'b1;
          end else begin
            d.ign = 1'b1;
          end
        end else if (take) begin
          d.cur = INSTR_IN;
          d.st = fwp_pkg::FWP_CHECK;
        end
      end
      fwp_pkg::FWP_CHECK: begin
        d.st = fwp_pkg::FWP_IDLE;
        if (is_wr) begin
          if (q.puw_done && q.write_enable_latch &&
              !((is_prog || is_erase) && prot) &&
              !(is_wrsr && !sr_ok)) begin
            d.busy = 1'b1;
            d.start = 1'b1;
            d.done = 1'b1;
            d.st = fwp_pkg::FWP_BUSY;
          end else begin
            d.ign = 1'b1;
          end
        end else if (q.cur.op == `FWP_OP_WREN) begin
          if (q.puw_done) begin
            d.write_enable_latch = 1'b1;
            d.done = 1'b1;
          end else begin
            d.ign = 1'b1;
          end
        end else if (q.cur.op == `FWP_OP_WRDI) begin
          d.write_enable_latch = 1'b0;
          d.done = 1'b1;
        end else if (q.cur.op == `FWP_OP_UNLOCK) begin
          d.done = lk_clr;
          d.ign = !lk_clr;
          d.write_enable_latch = q.write_enable_latch && !lk_clr;
        end else if (q.cur.op == `FWP_OP_PD) begin
          d.pd = 1'b1;
          d.done = 1'b1;
        end else begin
          d.done = 1'b1;
        end
      end
      fwp_pkg::FWP_BUSY: begin
        if (take) begin
          if ((INSTR_IN.op == `FWP_OP_RDSR1) ||
              (INSTR_IN.op == `FWP_OP_RDSR2) ||
              (INSTR_IN.op == `FWP_OP_RDSR3) ||
              (INSTR_IN.op == `FWP_OP_SUSP)) begin
            d.done = 1'b1;
          end else begin
            d.ign = 1'b1;
          end
        end
        if (OP_DONE_IN) begin
          d.busy = 1'b0;
          d.write_enable_latch = 1'b0;
          d.st = fwp_pkg::FWP_IDLE;
          if (q.cur.op == `FWP_OP_WRSR1) begin
            d.bp = q.cur.data[`FWP_S1_BP];
            d.tb = q.cur.data[`FWP_S1_TB];
            d.status_protect_bit = q.cur.data[`FWP_S1_SRP];
          end else if (q.cur.op == `FWP_OP_WRSR2) begin
            d.status_lock_bit = q.cur.data[`FWP_S2_SRL];
            d.cmp = q.cur.data[`FWP_S2_CMP];
          end else if (q.cur.op == `FWP_OP_WRSR3) begin
            d.protect_scheme_select = q.cur.data[`FWP_S3_WPS];
          end
        end
      end
      default: begin
        d.st = fwp_pkg::FWP_IDLE;
      end
    endcase
    if (!VCC_OK_IN) begin
      d = '0;
    end
    d.ready = VCC_OK_IN && (d.st != fwp_pkg::FWP_CHECK);
    d.sr1 = {d.status_protect_bit, d.tb, d.bp, d.write_enable_latch, d.busy};
    d.sr2 = {1'b0, d.cmp, 5'h00, d.status_lock_bit};
  end

  // state register, defaults after reset
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // lock bit store
  fwp_lock_mem u_lock (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .set_all_in(!VCC_OK_IN),
    .clr_en_in(lk_clr),
    .clr_idx_in(lk_clr_idx),
    .rd_idx_in(lk_rd_idx),
    .rd_out(lk_rd),
    .any_out(lk_any)
  );

  // outputs straight from state
  assign INSTR_READY_OUT = q.ready;
  assign INSTR_DONE_OUT = q.done;
  assign INSTR_IGNORED_OUT = q.ign;
  assign ARRAY_START_OUT = q.start;
  assign ARRAY_CMD_OUT = q.cur;
  assign STATUS1_OUT = q.sr1;
  assign STATUS2_OUT = q.sr2;
  assign PROT_SCHEME_OUT = q.protect_scheme_select;
  assign POWER_DOWN_OUT = q.pd;
  assign WRITE_READY_OUT = q.puw_done;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  a_supply_low_idle: assert property (!VCC_OK_IN |=>
    (!q.busy && !q.write_enable_latch && !q.pd && !q.ready && !q.puw_done))
    else $error("state not cleared under low supply");
  a_puw_no_wel: assert property (!q.puw_done |-> !q.write_enable_latch)
    else $error("latch set inside power-up delay");
  a_wren_sets: assert property (
    (q.st == fwp_pkg::FWP_CHECK && q.cur.op == `FWP_OP_WREN &&
     q.puw_done && VCC_OK_IN) |=> (q.write_enable_latch && STATUS1_OUT[1]))
    else $error("write enable did not set latch");
  a_nowel_refuse: assert property (
    (q.st == fwp_pkg::FWP_CHECK && is_wr && !q.write_enable_latch) |=>
    (!q.start && q.ign) || !$past(VCC_OK_IN))
    else $error("write taken without latch");
  a_done_clears: assert property (
    (q.st == fwp_pkg::FWP_BUSY && OP_DONE_IN) |=>
    (!q.busy && !q.write_enable_latch && STATUS1_OUT[1:0] == 2'b00))
    else $error("completion did not clear busy and latch");
  a_busy_ignore: assert property (
    (q.st == fwp_pkg::FWP_BUSY && take && VCC_OK_IN &&
     INSTR_IN.op == `FWP_OP_WREN) |=> (q.ign && !q.done))
    else $error("instruction obeyed while busy");
  a_pd_ignore: assert property (
    (q.pd && take && VCC_OK_IN && INSTR_IN.op != `FWP_OP_REL) |=>
    (q.ign && q.pd))
    else $error("instruction obeyed in power-down");
  a_lock_skip: assert property (
    (q.st == fwp_pkg::FWP_CHECK && q.protect_scheme_select && lk_rd &&
     (is_prog || (is_erase && !is_ce))) |=> !q.start)
    else $error("locked region written");
  a_hw_protect: assert property (
    (q.st == fwp_pkg::FWP_CHECK && is_wrsr && q.status_protect_bit && !q.status_lock_bit &&
     !WP_N_IN) |=> !q.start)
    else $error("status write taken with pin low");
  a_busy_with_start: assert property (
    q.start |-> (q.busy && STATUS1_OUT[0]) ##1 (q.busy || !$past(VCC_OK_IN) ||
    $past(OP_DONE_IN)))
    else $error("busy not set with operation start");
  a_wrdi_clears: assert property (
    (q.st == fwp_pkg::FWP_CHECK && q.cur.op == `FWP_OP_WRDI) |=>
    (!q.write_enable_latch && !STATUS1_OUT[1]))
    else $error("write disable did not clear latch");
  a_srl_refuse: assert property (
    (q.st == fwp_pkg::FWP_CHECK && is_wrsr && q.status_lock_bit) |=> !q.start)
    else $error("status write taken while locked down");
  a_range_skip: assert property (
    (q.st == fwp_pkg::FWP_CHECK && !q.protect_scheme_select && (is_prog || is_erase) &&
     prot) |=> (!q.start && q.write_enable_latch == $past(q.write_enable_latch)))
    else $error("range protected region written");
  a_pd_release: assert property (
    (q.pd && take && VCC_OK_IN && INSTR_IN.op == `FWP_OP_REL) |=>
    (!q.pd && q.done && !POWER_DOWN_OUT))
    else $error("release did not leave power-down");
  a_puw_blocks_start: assert property (
    (q.st == fwp_pkg::FWP_CHECK && is_wr && !q.puw_done) |=>
    (!q.start && !q.busy))
    else $error("write started inside power-up delay");
endmodule : fwp_protect

// [fwp_array_model.sv]
`timescale 1ns/1ps
module fwp_array_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // start and chosen duration
  input wire logic start_in,
  input wire logic [7:0] delay_in,
  // completion pulse
  output logic done_out
);
  logic [7:0] cnt_q;
  logic run_q;
  // counts the operation length, then pulses done for one cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 8'h00;
      run_q <= 1'h0;
      done_out <= 1'h0;
    end else begin
      done_out <= run_q && (cnt_q == 8'h00);
      if (start_in) begin
        run_q <= 1'h1;
        cnt_q <= delay_in;
      end else if (run_q && cnt_q == 8'h00) begin
        run_q <= 1'h0;
      end else if (run_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : fwp_array_model

// [flash_write_protect_status_bench.sv]
`timescale 1ns/1ps
`include "fwp_defs.svh"
module flash_write_protect_status_bench;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic vcc_ok = 1'h1;
  logic wp_n = 1'h1;
  logic valid = 1'h0;
  fwp_pkg::fwp_instr_type instr = '0;
  logic ready, done, ign, start, pscheme, pdown, wready, op_done;
  logic [7:0] s1, s2, last_s1;
  fwp_pkg::fwp_instr_type cmd;
  logic [7:0] eng_delay = 8'h03;
  int err_total = 0;
  int check_count = 0;
  // free running clock
  always #5 mclk = ~mclk;
  fwp_protect #(.PUW_CYCLES(20)) dut_u (.MCLK_IN(mclk), .RST_IN(rst),
    .VCC_OK_IN(vcc_ok), .WP_N_IN(wp_n), .INSTR_VALID_IN(valid),
    .INSTR_IN(instr), .INSTR_READY_OUT(ready), .INSTR_DONE_OUT(done),
    .INSTR_IGNORED_OUT(ign), .ARRAY_START_OUT(start), .ARRAY_CMD_OUT(cmd),
    .OP_DONE_IN(op_done), .STATUS1_OUT(s1), .STATUS2_OUT(s2),
    .PROT_SCHEME_OUT(pscheme), .POWER_DOWN_OUT(pdown),
    .WRITE_READY_OUT(wready));
  fwp_array_model eng_u (.clk_in(mclk), .rst_in(rst), .start_in(start),
    .delay_in(eng_delay), .done_out(op_done));
  task automatic compare(input string name, input logic [7:0] exp,
      input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : compare
  // sends one instruction, holds it until taken, judges the answer
  task automatic issue(input logic [7:0] op, input logic [24:0] addr,
      input logic [7:0] data, input logic exp_ok);
    logic r;
    int n;
    r = 1'h0;
    n = 0;
    @(posedge mclk);
    valid <= 1'h1;
    instr <= {op, addr, data};
    while (r !== 1'h1 && n < 60) begin
      @(negedge mclk);
      r = ready;
      n++;
      @(posedge mclk);
    end
    valid <= 1'h0;
    r = 1'h0;
    n = 0;
    while (r !== 1'h1 && n < 8) begin
      @(negedge mclk);
      r = done | ign;
      n++;
    end
    last_s1 = s1;
    compare("outcome", {6'h00, exp_ok, !exp_ok}, {6'h00, done, ign});
  endtask : issue
  task automatic wait_idle();
    int n;
    n = 0;
    while (s1[0] !== 1'h0 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    compare("wel_busy", 8'h00, {6'h00, s1[1:0]});
  endtask : wait_idle
  // write enable, then one write-type instruction
  task automatic wr_op(input logic [7:0] op, input logic [24:0] addr,
      input logic [7:0] data, input logic exp_ok);
    issue(`FWP_OP_WREN, 25'h000_0000, 8'h00, 1'h1);
    issue(op, addr, data, exp_ok);
    if (exp_ok) wait_idle();
  endtask : wr_op
  task automatic t_powerup();
    int n;
    compare("status1", 8'h00, s1);
    compare("status2", 8'h00, s2);
    compare("flags", 8'h00, {5'h00, pscheme, pdown, wready});
    issue(`FWP_OP_WREN, 25'h000_0000, 8'h00, 1'h0);
    n = 0;
    while (wready !== 1'h1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    compare("write_ready", 8'h01, {7'h00, wready});
    $display("test powerup finished");
  endtask : t_powerup
  task automatic t_latch();
    issue(`FWP_OP_PP, 25'h000_0000, 8'h00, 1'h0);
    issue(`FWP_OP_WREN, 25'h000_0000, 8'h00, 1'h1);
    compare("wel_set", 8'h02, s1);
    issue(`FWP_OP_WRDI, 25'h000_0000, 8'h00, 1'h1);
    compare("wel_clr", 8'h00, s1);
    $display("test latch finished");
  endtask : t_latch
  task automatic t_busy();
    eng_delay <= 8'h28;
    issue(`FWP_OP_WREN, 25'h000_0000, 8'h00, 1'h1);
    issue(`FWP_OP_PP, 25'h000_0100, 8'h00, 1'h1);
    compare("busy_set", 8'h03, {6'h00, last_s1[1:0]});
    compare("array_op", `FWP_OP_PP, cmd.op);
    issue(`FWP_OP_WREN, 25'h000_0000, 8'h00, 1'h0);
    issue(`FWP_OP_RDSR1, 25'h000_0000, 8'h00, 1'h1);
    issue(`FWP_OP_SUSP, 25'h000_0000, 8'h00, 1'h1);
    wait_idle();
    eng_delay <= 8'h03;
    $display("test busy finished");
  endtask : t_busy
  task automatic t_range();
    wr_op(`FWP_OP_WRSR1, 25'h000_0000, 8'h0C, 1'h1);
    compare("range_bits", 8'h0C, s1);
    wr_op(`FWP_OP_PP, 25'h1FF_0000, 8'h00, 1'h0);
    wr_op(`FWP_OP_PP, 25'h000_0000, 8'h00, 1'h1);
    wr_op(`FWP_OP_WRSR2, 25'h000_0000, 8'h40, 1'h1);
    compare("complement", 8'h40, s2);
    wr_op(`FWP_OP_PP, 25'h000_0000, 8'h00, 1'h0);
    wr_op(`FWP_OP_PP, 25'h1FF_0000, 8'h00, 1'h1);
    $display("test range finished");
  endtask : t_range
  task automatic t_locks();
    wr_op(`FWP_OP_WRSR3, 25'h000_0000, 8'h04, 1'h1);
    compare("scheme", 8'h01, {7'h00, pscheme});
    wr_op(`FWP_OP_PP, 25'h1FF_0000, 8'h00, 1'h0);
    wr_op(`FWP_OP_SE, 25'h064_0000, 8'h00, 1'h0);
    wr_op(`FWP_OP_UNLOCK, 25'h064_0000, 8'h00, 1'h1);
    wr_op(`FWP_OP_SE, 25'h064_0000, 8'h00, 1'h1);
    wr_op(`FWP_OP_PP, 25'h065_0000, 8'h00, 1'h0);
    $display("test locks finished");
  endtask : t_locks
  task automatic t_srlock();
    wr_op(`FWP_OP_WRSR1, 25'h000_0000, 8'h80, 1'h1);
    compare("srp_set", 8'h80, s1);
    @(posedge mclk);
    wp_n <= 1'h0;
    wr_op(`FWP_OP_WRSR1, 25'h000_0000, 8'h0C, 1'h0);
    @(posedge mclk);
    wp_n <= 1'h1;
    wr_op(`FWP_OP_WRSR2, 25'h000_0000, 8'h41, 1'h1);
    wr_op(`FWP_OP_WRSR1, 25'h000_0000, 8'h0C, 1'h0);
    compare("sr_kept", 8'h82, s1);
    $display("test srlock finished");
  endtask : t_srlock
  task automatic t_pdown();
    issue(`FWP_OP_WRDI, 25'h000_0000, 8'h00, 1'h1);
    issue(`FWP_OP_PD, 25'h000_0000, 8'h00, 1'h1);
    compare("pdown_on", 8'h01, {7'h00, pdown});
    issue(`FWP_OP_WREN, 25'h000_0000, 8'h00, 1'h0);
    issue(`FWP_OP_REL, 25'h000_0000, 8'h00, 1'h1);
    compare("pdown_off", 8'h00, {7'h00, pdown});
    $display("test pdown finished");
  endtask : t_pdown
  task automatic t_supply();
    @(posedge mclk);
    vcc_ok <= 1'h0;
    repeat (3) @(negedge mclk);
    compare("low_supply", 8'h00, {5'h00, ready, wready, pscheme});
    compare("low_status", 8'h00, s2);
    @(posedge mclk);
    vcc_ok <= 1'h1;
    issue(`FWP_OP_WREN, 25'h000_0000, 8'h00, 1'h0);
    $display("test supply finished");
  endtask : t_supply
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(negedge mclk);
    t_powerup();
    t_latch();
    t_busy();
    t_range();
    t_locks();
    t_srlock();
    t_pdown();
    t_supply();
    give_verdict();
  end
  // hang guard, well beyond the expected run
  initial begin
    #200_000;
    err_total++;
    give_verdict();
  end
endmodule : flash_write_protect_status_bench
